// file: logic/ovp_defines.vh
// constants shared by the overpower stage design files
`ifndef OVP_DEFINES_VH
`define OVP_DEFINES_VH

// timing
`define OVP_CLK_MHZ 100
`define OVP_CYCLE_MS 5
`define OVP_CYCLE_CLKS (`OVP_CYCLE_MS * 1000 * `OVP_CLK_MHZ)
`define OVP_PRE20_MS 20
`define OVP_PRE20_CYC (`OVP_PRE20_MS / `OVP_CYCLE_MS)
`define OVP_PRE200_MS 200
`define OVP_PRE200_CYC 6'd40
`define OVP_RESET_PCT 40'd97
`define OVP_RATIO_SCALE 40'd100

// register word indices
`define OVP_REG_CTRL 5'h00
`define OVP_REG_PICKUP 5'h01
`define OVP_REG_OPTIME 5'h02
`define OVP_REG_RSTTIME 5'h03
`define OVP_REG_GROUP 5'h04
`define OVP_REG_STATUS 5'h05
`define OVP_REG_RATIO 5'h06
`define OVP_REG_EXPTIME 5'h07
`define OVP_REG_REMAIN 5'h08
`define OVP_REG_CNT_START 5'h09
`define OVP_REG_CNT_TRIP 5'h0a
`define OVP_REG_CNT_BLK 5'h0b
`define OVP_REG_REC_SEL 5'h0c
`define OVP_REG_REC0 5'h10
`define OVP_REG_REC5 5'h15

// control register fields
`define OVP_CTRL_FORCE_EN 0
`define OVP_CTRL_FORCE_LSB 1
`define OVP_CTRL_CNT_CLR 3
`define OVP_CTRL_KEEP_LSB 4

// reset values
`define OVP_RST_PICKUP 24'h002710
`define OVP_RST_OPTIME 19'h00014
`define OVP_RST_RSTTIME 19'h00000
`define OVP_RST_KEEP 6'h3f

// fault record layout
`define OVP_REC_DEPTH 12
`define OVP_REC_LAST 4'hb
`define OVP_REC_W 168
`define OVP_REC_TS 0
`define OVP_REC_CODE 48
`define OVP_REC_PRE20 50
`define OVP_REC_FAULT 82
`define OVP_REC_PRE200 114
`define OVP_REC_REMAIN 146
`define OVP_REC_GROUP 165
`define OVP_HIST_DEPTH 64

`endif

// file: logic/ovp_ram.v
// simple dual port memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module ovp_ram #(
  parameter WIDTH = 32,
  parameter DEPTH = 64,
  parameter AW = 6
) (
  // clock and reset
  input wire clk_in,
  input wire reset_in,
  input wire ce_in,
  // write port
  input wire we_in,
  input wire [AW-1:0] waddr_in,
  input wire [WIDTH-1:0] wdata_in,
  // read port
  input wire [AW-1:0] raddr_in,
  output reg [WIDTH-1:0] rdata_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clk_in) begin
    if (ce_in && we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out <= {WIDTH{1'b0}};
    end else if (ce_in) begin
      rdata_out <= mem[raddr_in];
    end
  end
endmodule
`default_nettype wire

// file: logic/ovp_stage.v
// overpower protection stage with avalon-mm register slave
`include "ovp_defines.vh"
`timescale 1ns/100ps
`default_nettype none
// How it works
// - when forcing is permitted, a static setting forces the outcome.
// - power is compared with the pick-up setting; ratio is computed.
// - once picked up, release only below 97 % of pick-up setting.
// - general settings stand alone; pick-up settings may change live.
// - the blocking input is sampled at the start of each cycle.
// - pick-up without blocking raises start and runs trip timing.
// - pick-up under blocking raises blocked; no start, no timing.
// - blocking after start drops start and runs release timing.
// - trip and reset delays are definite time only.
// - outcome, expected operating time and signed remaining readable.
// - power to pick-up ratio readable in 0.01 steps.
// - on and off events per flag, each selectable for keeping.
// - every event carries a time stamp.
// - resettable counts of start, trip, blocked; outputs as pins.
// - exactly one stage.
// - record on each evaluation with an on event (one record if several fire together); keep twelve, overwrite oldest.
// - record holds time, event, powers, remaining time, group.
// - the program cycle and power refresh run on a 5 ms base.
module ovp_stage #(
  parameter CYCLE_CLKS = `OVP_CYCLE_CLKS
) (
  // clock, reset, enable
  input wire clk_in,
  input wire reset_in,
  input wire ce_in,
  // avalon-mm slave
  input wire [4:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  // measurement front end and blocking matrix
  input wire [31:0] measured_power_in,
  input wire meas_valid_in,
  input wire block_in,
  input wire [47:0] timestamp_in,
  // stage outputs
  output wire start_out,
  output wire trip_out,
  output wire blocked_out,
  output reg [1:0] outcome_out,
  output reg [5:0] evt_out,
  output reg [5:0] evt_keep_out,
  output reg [47:0] evt_stamp_out
);
  localparam [1:0] OUT_NORMAL = 2'd0;
  localparam [1:0] OUT_START = 2'd1;
  localparam [1:0] OUT_TRIP = 2'd2;
  localparam [1:0] OUT_BLOCKED = 2'd3;
  localparam [31:0] TICK_FULL = CYCLE_CLKS - 1;
  localparam [18:0] TICK_LAST = TICK_FULL[18:0];

  // {blocked, trip, start}; trip counts as started
  function [2:0] flags_of;
    input [1:0] oc;
    begin
      flags_of = {oc == OUT_BLOCKED, oc == OUT_TRIP,
                  oc == OUT_START || oc == OUT_TRIP};
    end
  endfunction

  // settings
  reg force_en_r;
  reg [1:0] force_val_r;
  reg [5:0] keep_r;
  reg [23:0] pickup_r;
  reg [18:0] optime_r;
  reg [18:0] rsttime_r;
  reg [2:0] group_r;
  reg [3:0] rec_sel_r;
  // cycle pipeline
  reg [18:0] tick_cnt_r;
  reg eval_r;
  reg blk_cyc_r;
  reg [31:0] meas_r;
  reg [31:0] pwr_cyc_r;
  reg [31:0] pre_sh_r [0:`OVP_PRE20_CYC-1];
  reg [5:0] hptr_r;
  // stage state
  reg picked_r;
  reg [18:0] op_cnt_r;
  reg [18:0] rel_cnt_r;
  reg [19:0] remain_r;
  reg [31:0] cnt_r [0:2];
  reg [3:0] wptr_r;
  reg [3:0] rec_cnt_r;
  // ratio divider
  reg [39:0] div_r;
  reg [24:0] rem_r;
  reg [5:0] div_cnt_r;
  reg [16:0] ratio_r;
  // bus
  reg [1:0] rd_stage_r;

  wire blk_s;
  wire tick = (tick_cnt_r == TICK_LAST);
  wire [31:0] hist_q;
  wire [`OVP_REC_W-1:0] rec_q;
  wire wr_ok = ce_in && avs_write_in;
  wire cnt_clr = wr_ok && avs_address_in == `OVP_REG_CTRL &&
                 avs_writedata_in[`OVP_CTRL_CNT_CLR];

  ovp_sync u_blk_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .d_in(block_in),
    .q_out(blk_s)
  );

  // ring of cycle samples, read 200 ms back
  ovp_ram #(.WIDTH(32), .DEPTH(`OVP_HIST_DEPTH), .AW(6)) u_hist (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .we_in(tick),
    .waddr_in(hptr_r),
    .wdata_in(meas_r),
    .raddr_in(hptr_r - `OVP_PRE200_CYC),
    .rdata_out(hist_q)
  );

  // pick-up with built-in 97 % hysteresis
  wire [39:0] p100 = {8'h00, pwr_cyc_r} * `OVP_RATIO_SCALE;
  wire [39:0] pset97 = {16'h0000, pickup_r} * `OVP_RESET_PCT;
  wire above = pwr_cyc_r > {8'h00, pickup_r};
  wire below = p100 < pset97;
  wire pick_nxt = picked_r ? !below : above;

  reg [18:0] op_nxt;
  reg [18:0] rel_nxt;
  reg [1:0] core_nxt;
  always @* begin
    op_nxt = op_cnt_r;
    rel_nxt = rel_cnt_r;
    core_nxt = OUT_NORMAL;
    if (pick_nxt && !blk_cyc_r) begin
      rel_nxt = 19'h00000;
      if (op_cnt_r < optime_r) begin
        op_nxt = op_cnt_r + 19'h00001;
      end
      core_nxt = (op_nxt >= optime_r) ? OUT_TRIP : OUT_START;
    end else begin
      core_nxt = pick_nxt ? OUT_BLOCKED : OUT_NORMAL;
      if (op_cnt_r != 19'h00000) begin
        // definite reset delay; pick-up back in time resumes the count
        if (rel_cnt_r >= rsttime_r) begin
          op_nxt = 19'h00000;
          rel_nxt = 19'h00000;
        end else begin
          rel_nxt = rel_cnt_r + 19'h00001;
        end
      end
    end
  end

  wire [1:0] out_nxt = force_en_r ? force_val_r : core_nxt;
  wire [2:0] f_old = flags_of(outcome_out);
  wire [2:0] f_new = flags_of(out_nxt);
  wire [2:0] ev_on = f_new & ~f_old;
  wire [2:0] ev_off = f_old & ~f_new;
  wire [19:0] rem_nxt = {1'b0, optime_r} - {1'b0, op_nxt};
  wire [1:0] rec_code = ev_on[1] ? OUT_TRIP :
                        ev_on[0] ? OUT_START : OUT_BLOCKED;
  wire rec_we = eval_r && (|ev_on);
  wire [`OVP_REC_W-1:0] rec_d = {group_r, rem_nxt[18:0], hist_q,
                                 pwr_cyc_r, pre_sh_r[`OVP_PRE20_CYC-1],
                                 rec_code, timestamp_in};

  ovp_ram #(.WIDTH(`OVP_REC_W), .DEPTH(`OVP_REC_DEPTH), .AW(4)) u_rec (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .we_in(rec_we),
    .waddr_in(wptr_r),
    .wdata_in(rec_d),
    .raddr_in(rec_sel_r),
    .rdata_out(rec_q)
  );

  assign start_out = f_old[0];
  assign trip_out = f_old[1];
  assign blocked_out = f_old[2];

  // program cycle: sample block and power, then evaluate one clock later
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      tick_cnt_r <= 19'h00000;
      eval_r <= 1'b0;
      blk_cyc_r <= 1'b0;
      meas_r <= 32'h00000000;
      pwr_cyc_r <= 32'h00000000;
      hptr_r <= 6'h00;
    end else if (ce_in) begin
      tick_cnt_r <= tick ? 19'h00000 : tick_cnt_r + 19'h00001;
      eval_r <= tick;
      if (meas_valid_in) begin
        meas_r <= measured_power_in;
      end
      if (tick) begin
        blk_cyc_r <= blk_s;
        pwr_cyc_r <= meas_r;
        hptr_r <= hptr_r + 6'h01;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `OVP_PRE20_CYC; gi = gi + 1) begin : g_pre
      always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
          pre_sh_r[gi] <= 32'h00000000;
        end else if (ce_in && eval_r) begin
          pre_sh_r[gi] <= (gi == 0) ? pwr_cyc_r :
                          pre_sh_r[(gi == 0) ? 0 : gi - 1];
        end
      end
    end
    // a clear in the same cycle as an event still counts that event
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_cnt
      always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
          cnt_r[gi] <= 32'h00000000;
        end else if (ce_in) begin
          cnt_r[gi] <= (cnt_clr ? 32'h00000000 : cnt_r[gi]) +
                       {31'h00000000, eval_r & ev_on[gi]};
        end
      end
    end
  endgenerate

  // stage state, events and record pointers
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      picked_r <= 1'b0;
      op_cnt_r <= 19'h00000;
      rel_cnt_r <= 19'h00000;
      remain_r <= 20'h00000;
      outcome_out <= OUT_NORMAL;
      evt_out <= 6'h00;
      evt_keep_out <= 6'h00;
      evt_stamp_out <= 48'h000000000000;
      wptr_r <= 4'h0;
      rec_cnt_r <= 4'h0;
    end else if (ce_in) begin
      evt_out <= 6'h00;
      evt_keep_out <= 6'h00;
      if (eval_r) begin
        picked_r <= pick_nxt;
        op_cnt_r <= op_nxt;
        rel_cnt_r <= rel_nxt;
        remain_r <= rem_nxt;
        outcome_out <= out_nxt;
        evt_out <= {ev_off, ev_on};
        evt_keep_out <= {ev_off, ev_on} & keep_r;
        evt_stamp_out <= timestamp_in;
      end
      if (rec_we) begin
        wptr_r <= (wptr_r == `OVP_REC_LAST) ? 4'h0 : wptr_r + 4'h1;
        if (rec_cnt_r != `OVP_REC_LAST + 4'h1) begin
          rec_cnt_r <= rec_cnt_r + 4'h1;
        end
      end
    end
  end

  // serial divider: ratio in hundredths, saturates at the top
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_r <= 40'h0000000000;
      rem_r <= 25'h0000000;
      div_cnt_r <= 6'h00;
      ratio_r <= 17'h00000;
    end else if (ce_in) begin
      if (eval_r) begin
        div_r <= p100;
        rem_r <= 25'h0000000;
        div_cnt_r <= 6'd40;
      end else if (div_cnt_r != 6'h00) begin
        if ({rem_r[23:0], div_r[39]} >= {1'b0, pickup_r}) begin
          rem_r <= {rem_r[23:0], div_r[39]} - {1'b0, pickup_r};
          div_r <= {div_r[38:0], 1'b1};
        end else begin
          rem_r <= {rem_r[23:0], div_r[39]};
          div_r <= {div_r[38:0], 1'b0};
        end
        div_cnt_r <= div_cnt_r - 6'h01;
      end else if (|div_r[39:17] || pickup_r == 24'h000000) begin
        ratio_r <= 17'h1ffff;
      end else begin
        ratio_r <= div_r[16:0];
      end
    end
  end

  // avalon-mm: writes complete at once, reads after two wait cycles;
  // a low clock enable stalls a write so that it is not lost
  assign avs_waitrequest_out = (avs_write_in && !ce_in) ||
                               (avs_read_in && rd_stage_r != 2'd2);

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      force_en_r <= 1'b0;
      force_val_r <= OUT_NORMAL;
      keep_r <= `OVP_RST_KEEP;
      pickup_r <= `OVP_RST_PICKUP;
      optime_r <= `OVP_RST_OPTIME;
      rsttime_r <= `OVP_RST_RSTTIME;
      group_r <= 3'h0;
      rec_sel_r <= 4'h0;
      rd_stage_r <= 2'd0;
      avs_readdata_out <= 32'h00000000;
    end else if (ce_in) begin
      if (avs_write_in) begin
        case (avs_address_in)
          `OVP_REG_CTRL: begin
            // general settings: untouched by group changes
            force_en_r <= avs_writedata_in[`OVP_CTRL_FORCE_EN];
            force_val_r <= avs_writedata_in[`OVP_CTRL_FORCE_LSB +: 2];
            keep_r <= avs_writedata_in[`OVP_CTRL_KEEP_LSB +: 6];
          end
          `OVP_REG_PICKUP: pickup_r <= avs_writedata_in[23:0];
          `OVP_REG_OPTIME: optime_r <= avs_writedata_in[18:0];
          `OVP_REG_RSTTIME: rsttime_r <= avs_writedata_in[18:0];
          `OVP_REG_GROUP: group_r <= avs_writedata_in[2:0];
          `OVP_REG_REC_SEL: begin
            rec_sel_r <= (avs_writedata_in[3:0] > `OVP_REC_LAST) ?
                         `OVP_REC_LAST : avs_writedata_in[3:0];
          end
          default: begin
          end
        endcase
      end
      if (!avs_read_in) begin
        rd_stage_r <= 2'd0;
      end else if (rd_stage_r == 2'd2) begin
        rd_stage_r <= 2'd0;
      end else begin
        rd_stage_r <= rd_stage_r + 2'd1;
      end
      if (avs_read_in && rd_stage_r == 2'd1) begin
        case (avs_address_in)
          `OVP_REG_CTRL: avs_readdata_out <= {22'h000000, keep_r,
                                              1'b0, force_val_r, force_en_r};
          `OVP_REG_PICKUP: avs_readdata_out <= {8'h00, pickup_r};
          `OVP_REG_OPTIME: avs_readdata_out <= {13'h0000, optime_r};
          `OVP_REG_RSTTIME: avs_readdata_out <= {13'h0000, rsttime_r};
          `OVP_REG_GROUP: avs_readdata_out <= {29'h00000000, group_r};
          `OVP_REG_STATUS: avs_readdata_out <= {28'h0000000, blk_cyc_r,
                                                picked_r, outcome_out};
          `OVP_REG_RATIO: avs_readdata_out <= {15'h0000, ratio_r};
          `OVP_REG_EXPTIME: avs_readdata_out <= {13'h0000, optime_r};
          `OVP_REG_REMAIN: avs_readdata_out <= {{12{remain_r[19]}},
                                                remain_r};
          `OVP_REG_CNT_START: avs_readdata_out <= cnt_r[0];
          `OVP_REG_CNT_TRIP: avs_readdata_out <= cnt_r[1];
          `OVP_REG_CNT_BLK: avs_readdata_out <= cnt_r[2];
          `OVP_REG_REC_SEL: avs_readdata_out <= {16'h0000, rec_cnt_r,
                                                 wptr_r, 4'h0, rec_sel_r};
          `OVP_REG_REC0: avs_readdata_out <= rec_q[`OVP_REC_TS +: 32];
          `OVP_REG_REC0 + 5'h01: avs_readdata_out <= {11'h000,
              rec_q[`OVP_REC_GROUP +: 3], rec_q[`OVP_REC_CODE +: 2],
              rec_q[`OVP_REC_TS + 32 +: 16]};
          `OVP_REG_REC0 + 5'h02: avs_readdata_out <= rec_q[`OVP_REC_PRE20 +: 32];
          `OVP_REG_REC0 + 5'h03: avs_readdata_out <= rec_q[`OVP_REC_FAULT +: 32];
          `OVP_REG_REC0 + 5'h04: avs_readdata_out <= rec_q[`OVP_REC_PRE200 +: 32];
          `OVP_REG_REC5: avs_readdata_out <= {13'h0000,
                                              rec_q[`OVP_REC_REMAIN +: 19]};
          default: avs_readdata_out <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: logic/ovp_sync.v
// two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/100ps
`default_nettype none
module ovp_sync (
  // clock and reset
  input wire clk_in,
  input wire reset_in,
  input wire ce_in,
  // data
  input wire d_in,
  output reg q_out
);
  reg meta_r;

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_r <= 1'b0;
      q_out <= 1'b0;
    end else if (ce_in) begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// file: testbench/ovp_front_model.sv
// measurement front end and blocking matrix model
`timescale 1ns/100ps
`default_nettype none
module ovp_front_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // scenario control
  input wire logic [31:0] power_set_in,
  input wire logic block_set_in,
  input wire logic slow_in,
  // toward the stage
  output var logic [31:0] measured_power_out,
  output var logic meas_valid_out,
  output var logic block_out,
  output var logic [47:0] timestamp_out
);
  logic [5:0] div_r;
  // outside the strobe the bus shows garbage so a late latch is caught
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_r <= 6'h00;
      measured_power_out <= 32'h0;
      meas_valid_out <= 1'b0;
      block_out <= 1'b0;
      timestamp_out <= 48'h0;
    end else begin
      div_r <= (div_r != 6'h00) ? div_r - 6'h01 :
        (slow_in ? 6'h27 : 6'h08);
      meas_valid_out <= (div_r == 6'h00);
      measured_power_out <= (div_r == 6'h00) ? power_set_in : ~power_set_in;
      block_out <= block_set_in;
      timestamp_out <= timestamp_out + 48'h1;
    end
  end
endmodule
`default_nettype wire

// file: testbench/ovp_stage_props.sv
// port checker for the overpower stage
`timescale 1ns/100ps
`default_nettype none
module ovp_stage_props (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // register bus
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  // stage outputs
  input wire logic start_out,
  input wire logic trip_out,
  input wire logic blocked_out,
  input wire logic [1:0] outcome_out,
  input wire logic [5:0] evt_out,
  input wire logic [5:0] evt_keep_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in || !ce_in);
  sequence s_busy; avs_waitrequest_out [*2]; endsequence
  sequence s_done; !avs_waitrequest_out; endsequence
  property p_rd_wait; $rose(avs_read_in) |-> s_busy ##1 s_done; endproperty
  property p_wr_nowait; avs_write_in |-> !avs_waitrequest_out; endproperty
  property p_flags;
    trip_out == (outcome_out == 2'h2) && blocked_out == (outcome_out == 2'h3)
      && start_out == (outcome_out == 2'h1 || outcome_out == 2'h2);
  endproperty
  property p_blk_nostart; blocked_out |-> !start_out && !evt_out[0];
  endproperty
  property p_pulse; |evt_out |=> evt_out == 6'h00; endproperty
  property p_keep; (evt_keep_out & ~evt_out) == 6'h00; endproperty
  property p_trip_on; $rose(trip_out) |-> evt_out[1]; endproperty
  property p_trip_off; $fell(trip_out) |-> evt_out[4]; endproperty
  property p_start_on;
    $past(outcome_out) == 2'h0 && outcome_out == 2'h1 |-> evt_out[0];
  endproperty
  property p_hold; $changed(outcome_out) |=> $stable(outcome_out) [*8];
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read answer not after two wait cycles");
  a_wr_nowait: assert property (p_wr_nowait)
    else $error("write stalled");
  a_flags: assert property (p_flags)
    else $error("flag pins disagree with outcome");
  a_blk_nostart: assert property (p_blk_nostart)
    else $error("start seen while blocked");
  a_pulse: assert property (p_pulse)
    else $error("event longer than one cycle");
  a_keep: assert property (p_keep)
    else $error("kept event without event");
  a_trip_on: assert property (p_trip_on)
    else $error("trip rose without trip on event");
  a_trip_off: assert property (p_trip_off)
    else $error("trip fell without trip off event");
  a_start_on: assert property (p_start_on)
    else $error("start without start on event");
  a_hold: assert property (p_hold)
    else $error("outcome changed between evaluations");
endmodule
bind ovp_stage ovp_stage_props u_props (.clk_in(clk_in),
  .reset_in(reset_in), .ce_in(ce_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
  .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
  .outcome_out(outcome_out), .evt_out(evt_out), .evt_keep_out(evt_keep_out));
`default_nettype wire

// file: testbench/tb_overpower_protection_stage.sv
// self-checking bench for the overpower protection stage
`include "ovp_defines.vh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, g); \
  end \
end
module tb_overpower_protection_stage;
  localparam int CYC = 50;
  logic clk_in = 1'b0;
  logic reset_in = 1'b0;
  logic ce_in = 1'b1;
  logic [4:0] avs_address_in = 5'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out, measured_power_in;
  logic avs_waitrequest_out, meas_valid_in, block_in;
  logic start_out, trip_out, blocked_out;
  logic [47:0] timestamp_in, evt_stamp_out;
  logic [1:0] outcome_out;
  logic [5:0] evt_out, evt_keep_out;
  logic [31:0] power_r = 32'h0;
  logic block_r = 1'b0;
  logic slow_r = 1'b0;
  logic [5:0] keep_r = 6'h3f;
  int error_cnt = 0;
  int checks = 0;
  int rec_n = 0;
  always #5 clk_in = ~clk_in;
  ovp_stage #(.CYCLE_CLKS(CYC)) uut (.clk_in(clk_in), .reset_in(reset_in),
    .ce_in(ce_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .measured_power_in(measured_power_in), .meas_valid_in(meas_valid_in),
    .block_in(block_in), .timestamp_in(timestamp_in), .start_out(start_out),
    .trip_out(trip_out), .blocked_out(blocked_out),
    .outcome_out(outcome_out), .evt_out(evt_out),
    .evt_keep_out(evt_keep_out), .evt_stamp_out(evt_stamp_out));
  ovp_front_model u_front (.clk_in(clk_in), .reset_in(reset_in),
    .power_set_in(power_r), .block_set_in(block_r), .slow_in(slow_r),
    .measured_power_out(measured_power_in), .meas_valid_out(meas_valid_in),
    .block_out(block_in), .timestamp_out(timestamp_in));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic hang(input string what);
    error_cnt++;
    $display("[ERR] %s expected answer seen none", what);
    print_verdict();
  endtask
  task automatic bus(input logic wr, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    n = 0;
    // the answer is taken at the rising edge that sees waitrequest low
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    if (avs_waitrequest_out !== 1'b0) hang("bus");
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e, string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(nm, e, q)
  endtask
  task automatic drive(input logic [31:0] p, input logic b);
    @(posedge clk_in);
    power_r <= p;
    block_r <= b;
  endtask
  task automatic cyc(input int n);
    repeat (n * CYC) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  task automatic wait_evt(input int b, output int c);
    c = 0;
    do begin
      @(negedge clk_in);
      c++;
    end while (evt_out[b] !== 1'b1 && c < 40 * CYC);
    if (c >= 40 * CYC) hang("event");
  endtask
  function automatic int gap(input int op);
    return (op - 1) * CYC;
  endfunction
  function automatic logic [3:0] stored(input int n);
    return (n > 12) ? 4'hc : 4'(n);
  endfunction
  always @(negedge clk_in) begin
    if (!reset_in && evt_out !== 6'h00) begin
      `CHK("keep", evt_out & keep_r, evt_keep_out)
      `CHK("stamp", 48'h1, timestamp_in - evt_stamp_out)
      if (|evt_out[2:0]) rec_n++;
    end
  end
  initial begin
    int c, op, r, pk, i, m;
    logic [31:0] q;
    reset_in <= 1'b1;
    void'($urandom(83));
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(`OVP_REG_CTRL, 32'h3f0, "ctrl");
    rd(`OVP_REG_PICKUP, 32'h2710, "pickup");
    rd(`OVP_REG_OPTIME, 32'h14, "optime");
    rd(`OVP_REG_STATUS, 32'h0, "status");
    rd(5'h1f, 32'h0, "unmapped");
    wr(`OVP_REG_EXPTIME, 32'h55);
    rd(`OVP_REG_EXPTIME, 32'h14, "exptime ro");
    // a write while the clock enable is low must wait, not vanish
    ce_in <= 1'b0;
    fork
      wr(`OVP_REG_GROUP, 32'h5);
      begin
        repeat (3) @(posedge clk_in);
        ce_in <= 1'b1;
      end
    join
    rd(`OVP_REG_GROUP, 32'h5, "group after freeze");
    $display("test reset values done");
    keep_r = 6'($urandom);
    wr(`OVP_REG_CTRL, {22'h0, keep_r, 4'h0});
    for (i = 0; i < 3; i++) begin
      op = 2 + $urandom % 4;
      r = 101 + $urandom % 200;
      pk = 100 * (50 + $urandom % 100);
      slow_r <= 1'($urandom);
      wr(`OVP_REG_OPTIME, 32'(op));
      wr(`OVP_REG_PICKUP, 32'(pk));
      drive(32'(r * pk / 100), 1'b0);
      wait_evt(0, c);
      wait_evt(1, c);
      `CHK("trip delay", gap(op), c)
      rd(`OVP_REG_EXPTIME, 32'(op), "exptime");
      rd(`OVP_REG_REMAIN, 32'h0, "remain");
      cyc(1);
      rd(`OVP_REG_RATIO, 32'(r), "ratio");
      drive(32'(pk * 97 / 100), 1'b0);
      cyc(3);
      `CHK("held at reset ratio", 2'h2, outcome_out)
      drive(32'(pk * 97 / 100 - 1), 1'b0);
      wait_evt(4, c);
      `CHK("released", 2'h0, outcome_out)
      rd(`OVP_REG_CNT_TRIP, 32'(i + 1), "trips");
      drive(32'h0, 1'b0);
      cyc(2);
    end
    $display("test pick-up and trip done");
    drive(32'h0, 1'b1);
    cyc(2);
    drive(32'(2 * pk), 1'b1);
    wait_evt(2, c);
    `CHK("no start under block", 1'b0, start_out)
    cyc(op + 2);
    `CHK("stays blocked", 2'h3, outcome_out)
    rd(`OVP_REG_CNT_START, 32'h3, "starts");
    rd(`OVP_REG_CNT_BLK, 32'h1, "blocks");
    drive(32'h0, 1'b1);
    wait_evt(5, c);
    drive(32'h0, 1'b0);
    cyc(2);
    $display("test blocked pick-up done");
    wr(`OVP_REG_OPTIME, 32'ha);
    drive(32'(2 * pk), 1'b0);
    wait_evt(0, c);
    drive(32'(2 * pk), 1'b1);
    wait_evt(3, c);
    `CHK("start dropped", 1'b0, start_out)
    cyc(12);
    `CHK("no trip", 1'b0, trip_out)
    drive(32'h0, 1'b0);
    cyc(3);
    $display("test block after start done");
    wr(`OVP_REG_RSTTIME, 32'h14);
    drive(32'(2 * pk), 1'b0);
    wait_evt(0, c);
    drive(32'h0, 1'b0);
    wait_evt(3, op);
    drive(32'(2 * pk), 1'b0);
    wait_evt(0, c);
    wait_evt(1, c);
    `CHK("resumed delay", gap(10) - op, c)
    drive(32'h0, 1'b0);
    wait_evt(4, c);
    rd(`OVP_REG_REMAIN, 32'h0, "remain held");
    wr(`OVP_REG_RSTTIME, 32'h0);
    $display("test reset delay done");
    for (m = 0; m < 4; m++) begin
      wr(`OVP_REG_CTRL, {22'h0, keep_r, 1'b0, 2'(m), 1'b1});
      cyc(2);
      `CHK("forced", 2'(m), outcome_out)
    end
    wr(`OVP_REG_CTRL, {22'h0, keep_r, 4'h4});
    cyc(2);
    `CHK("not forced", 2'h0, outcome_out)
    $display("test forcing done");
    bus(1'b0, `OVP_REG_REC_SEL, 32'h0, q);
    `CHK("records", stored(rec_n), q[15:12])
    `CHK("write slot", 4'(rec_n % 12), q[11:8])
    wr(`OVP_REG_REC_SEL, 32'((rec_n - 1) % 12));
    rd(`OVP_REG_REC0 + 5'h01, 32'h00170000, "newest record");
    wr(`OVP_REG_CTRL, {22'h0, keep_r, 4'h8});
    rd(`OVP_REG_CNT_START, 32'h0, "count cleared");
    rd(`OVP_REG_CTRL, {22'h0, keep_r, 4'h0}, "clear self");
    $display("test records and counters done");
    print_verdict();
  end
endmodule
`default_nettype wire
